/* File: pic_check_unit.sv */
// Protection instruction check unit: decodes system opcodes and classifies faults.
// Assumes an APB master on the core clock; all state is sampled on CLK_I.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`include "pic_params.svh"

module pic_check_unit (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Bus lock
  output logic             BUS_LOCK_O
);

  // -------------------------------------------------------------------------
  // Register file
  // -------------------------------------------------------------------------
  // Control: [0] start, [1] protected_mode, [3:2] current_privilege_level,
  // [5:4] io_privilege_threshold, [7:6] requested_privilege_level,
  // [9:8] descriptor_privilege_level, [10] present, [11] stack load,
  // [12] segment load, [13] far transfer privilege broken, [14] privileged op,
  // [15] io sensitive, [16] flag load, [17] status word load, [18] new protected_mode_flag bit,
  // [19] lock designated, [20] memory operand, [21] immediate, [22] stack operand,
  // [23] access rights bad, [24] coprocessor, [25] multiply, [26] transfer,
  // [31:27] reserved. Instruction bytes are written at the status offset.
  logic [31:0] ctrl_reg;
  logic [23:0] instr_reg;
  logic [31:0] seglim_reg;
  logic [31:0] codelim_reg;
  logic [31:0] operand_reg;
  logic [31:0] result_reg;
  logic [31:0] faults_reg;
  logic [31:0] flags_reg;
  pic_pkg::pic_state_e state_reg;
  pic_pkg::pic_state_e state_next;
  logic [7:0]  count_reg;
  pic_pkg::pic_result_s res_reg;
  pic_pkg::pic_result_s res_next;

  logic apb_write;
  logic apb_read;
  logic start;
  assign apb_write = PSEL_I && PENABLE_I && PWRITE_I;
  assign apb_read  = PSEL_I && !PWRITE_I;
  assign start     = apb_write && (PADDR_I == `PIC_ADDR_CTRL) && PWDATA_I[0] && (state_reg == pic_pkg::PIC_IDLE);

  // Zero-wait slave: the answer comes in the access phase itself.
  assign PREADY_O  = 1'b1;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PSLVERR_O <= 1'b0;
    end else begin
      PSLVERR_O <= 1'b0;
    end
  end

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `PIC_ADDR_CTRL) || (a == `PIC_ADDR_STATUS) || (a == `PIC_ADDR_RESULT) ||
             (a == `PIC_ADDR_FAULTS) || (a == `PIC_ADDR_SEGLIM) || (a == `PIC_ADDR_CODELIM);
  endfunction

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl_reg    <= 32'h00000000;
      instr_reg   <= 24'h000000;
      seglim_reg  <= 32'h00000000;
      codelim_reg <= 32'h00000000;
      operand_reg <= 32'h00000000;
    end else if (apb_write) begin
      unique case (PADDR_I)
        `PIC_ADDR_CTRL:    ctrl_reg    <= {5'h0, PWDATA_I[26:1], 1'b0};
        `PIC_ADDR_STATUS:  instr_reg   <= PWDATA_I[23:0];
        `PIC_ADDR_RESULT:  operand_reg <= PWDATA_I;
        `PIC_ADDR_SEGLIM:  seglim_reg  <= PWDATA_I;
        `PIC_ADDR_CODELIM: codelim_reg <= PWDATA_I;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h00000000;
    end else if (apb_read && !PENABLE_I) begin
      unique case (PADDR_I)
        `PIC_ADDR_CTRL:    PRDATA_O <= ctrl_reg;
        `PIC_ADDR_STATUS:  PRDATA_O <= {4'h0, state_reg, instr_reg};
        `PIC_ADDR_RESULT:  PRDATA_O <= result_reg;
        `PIC_ADDR_FAULTS:  PRDATA_O <= faults_reg;
        `PIC_ADDR_SEGLIM:  PRDATA_O <= flags_reg;
        `PIC_ADDR_CODELIM: PRDATA_O <= codelim_reg;
        default:           PRDATA_O <= 32'h00000000;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Decode and fault classification
  // -------------------------------------------------------------------------
  pic_pkg::pic_instr_s ins;
  logic       pmode;
  logic [1:0] current_privilege_level;
  logic [1:0] io_privilege_threshold;
  logic [2:0] regf;
  logic       is_sys0;
  logic       is_sys1;
  assign ins     = pic_pkg::pic_instr_s'(instr_reg);
  assign pmode   = ctrl_reg[1];
  assign current_privilege_level = ctrl_reg[3:2];
  assign io_privilege_threshold  = ctrl_reg[5:4];
  assign regf    = ins.modrm_byte[5:3];
  assign is_sys0 = (ins.escape_byte == `PIC_ESCAPE_BYTE) && (ins.second_byte == `PIC_SECOND_SYS0);
  assign is_sys1 = (ins.escape_byte == `PIC_ESCAPE_BYTE) && (ins.second_byte == `PIC_SECOND_SYS1);

  // Rounded-up base-two log of a magnitude.
  function automatic logic [7:0] ceil_log2(input logic [31:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 32; i++) begin
      if (v > (32'h00000001 << i)) begin
        n = 8'(i + 1);
      end
    end
    ceil_log2 = n;
  endfunction

  logic [31:0] mag;
  assign mag = operand_reg[31] ? 32'(-operand_reg) : operand_reg;

  always_comb begin
    logic       mem;
    logic       prot_only;
    logic       desc_access;
    logic [7:0] b;
    logic [7:0] lg;
    mem         = ins.modrm_byte[7:6] != 2'h3;
    prot_only   = 1'b0;
    desc_access = 1'b0;
    res_next    = '0;
    b           = ctrl_reg[20] ? (ctrl_reg[21] ? `PIC_B_MI : `PIC_B_MR)
                               : (ctrl_reg[21] ? `PIC_B_RI : `PIC_B_RR);
    lg          = ceil_log2(mag);
    if (is_sys0 && regf == `PIC_REG_011) begin
      prot_only = 1'b1;
      desc_access = 1'b1;
      res_next.clocks = mem ? `PIC_CLK_TR_LOAD_M : `PIC_CLK_TR_LOAD;
    end else if (is_sys0 && (regf == `PIC_REG_000 || regf == `PIC_REG_001)) begin
      prot_only = 1'b1;
      res_next.clocks = `PIC_CLK_LCL_STORE;
    end else if (is_sys0 && (regf == `PIC_REG_100 || regf == `PIC_REG_101)) begin
      prot_only = 1'b1;
      desc_access = 1'b1;
      res_next.clocks = (regf == `PIC_REG_100) ? (mem ? `PIC_CLK_RD_VFY_M : `PIC_CLK_RD_VFY)
                                               : (mem ? `PIC_CLK_WR_VFY_M : `PIC_CLK_WR_VFY);
      // Selector privilege violations only clear the zero flag.
      res_next.zero_flag = (ctrl_reg[7:6] <= ctrl_reg[9:8]) &&
                           (current_privilege_level <= ctrl_reg[9:8]);
    end else if (is_sys1 && (regf == `PIC_REG_000 || regf == `PIC_REG_001)) begin
      res_next.clocks = `PIC_CLK_TBL_STORE;
    end else if (is_sys1 && (regf == `PIC_REG_010 || regf == `PIC_REG_011)) begin
      res_next.clocks = `PIC_CLK_TBL_LOAD;
    end else if (ctrl_reg[25]) begin
      res_next.clocks = ((operand_reg == 32'h00000000) ? `PIC_MUL_MIN
                        : ((lg > `PIC_MUL_MIN) ? lg : `PIC_MUL_MIN)) + b;
    end
    res_next.lock = ctrl_reg[19] || (desc_access && pmode);
    // Priority order: the first matching fault wins and suppresses write-back.
    if (prot_only && !pmode) begin
      res_next.fault = 1'b1;
      res_next.vector = `PIC_VEC_INVALID;
    end else if (ctrl_reg[24] && pmode && ctrl_reg[23]) begin
      res_next.fault = 1'b1;
      res_next.vector = ctrl_reg[22] ? `PIC_VEC_STACK : `PIC_VEC_GENERAL;
    end else if (!pmode && ctrl_reg[20] && seglim_reg > `PIC_REAL_LIMIT) begin
      res_next.fault = 1'b1;
      res_next.vector = ctrl_reg[22] ? `PIC_VEC_STACK : `PIC_VEC_GENERAL;
    end else if (pmode && ctrl_reg[20] && ctrl_reg[23]) begin
      res_next.fault = 1'b1;
      res_next.vector = ctrl_reg[22] ? `PIC_VEC_STACK : `PIC_VEC_GENERAL;
    end else if (pmode && ctrl_reg[12] &&
                 (ctrl_reg[9:8] < current_privilege_level || ctrl_reg[9:8] < ctrl_reg[7:6])) begin
      res_next.fault = 1'b1;
      res_next.vector = `PIC_VEC_GENERAL;
    end else if (pmode && ctrl_reg[12] && !ctrl_reg[10]) begin
      res_next.fault = 1'b1;
      res_next.vector = ctrl_reg[11] ? `PIC_VEC_STACK : `PIC_VEC_NOT_PRES;
    end else if (pmode && ctrl_reg[13]) begin
      res_next.fault = 1'b1;
      res_next.vector = `PIC_VEC_GENERAL;
    end else if (ctrl_reg[26] && operand_reg > codelim_reg) begin
      res_next.fault = 1'b1;
      res_next.vector = `PIC_VEC_GENERAL;
    end else if (pmode && ctrl_reg[14] && current_privilege_level != 2'h0) begin
      res_next.fault = 1'b1;
      res_next.vector = `PIC_VEC_GENERAL;
    end else if (pmode && ctrl_reg[15] && current_privilege_level > io_privilege_threshold) begin
      res_next.fault = 1'b1;
      res_next.vector = `PIC_VEC_GENERAL;
    end
    res_next.write_back = !res_next.fault;
  end

  // -------------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pic_pkg::PIC_IDLE:  if (start) state_next = pic_pkg::PIC_CHECK;
      pic_pkg::PIC_CHECK: state_next = res_next.fault ? pic_pkg::PIC_DONE : pic_pkg::PIC_EXEC;
      pic_pkg::PIC_EXEC:  if (count_reg <= 8'h01) state_next = pic_pkg::PIC_DONE;
      pic_pkg::PIC_DONE:  state_next = pic_pkg::PIC_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_reg <= pic_pkg::PIC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      res_reg   <= '0;
      count_reg <= 8'h00;
    end else if (state_reg == pic_pkg::PIC_CHECK) begin
      res_reg   <= res_next;
      count_reg <= res_next.clocks;
    end else if (state_reg == pic_pkg::PIC_EXEC) begin
      count_reg <= count_reg - 8'h01;
    end
  end

  // Lock is held for the whole execution so descriptor reads and writes stay atomic.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      BUS_LOCK_O <= 1'b0;
    end else begin
      BUS_LOCK_O <= (state_next == pic_pkg::PIC_EXEC) &&
                    ((state_reg == pic_pkg::PIC_CHECK) ? res_next.lock : res_reg.lock);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      result_reg <= 32'h00000000;
      faults_reg <= 32'h00000000;
    end else if (state_reg == pic_pkg::PIC_DONE) begin
      result_reg <= {13'h0, res_reg.zero_flag, res_reg.write_back, res_reg.lock, res_reg.clocks, res_reg.vector};
      faults_reg <= {23'h0, res_reg.fault, res_reg.vector};
    end
  end

  // Architectural flags: [9] interrupt, [13:12] io threshold, [17] virtual_86_flag, [31] protected_mode_flag.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      flags_reg <= 32'h00000000;
    end else if (state_reg == pic_pkg::PIC_DONE && res_reg.write_back) begin
      if (ctrl_reg[16]) begin
        if (current_privilege_level <= io_privilege_threshold) flags_reg[9] <= operand_reg[9];
        if (current_privilege_level == 2'h0) begin
          flags_reg[13:12] <= operand_reg[13:12];
          flags_reg[17]    <= operand_reg[17];
        end
      end
      if (ctrl_reg[17]) begin
        flags_reg[31] <= flags_reg[31] | ctrl_reg[18];
      end
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  property p_invalid_real;
    @(posedge CLK_I) disable iff (RST_I)
      (state_reg == pic_pkg::PIC_CHECK && !pmode && is_sys0 && regf == `PIC_REG_011)
      |=> (res_reg.fault && res_reg.vector == `PIC_VEC_INVALID);
  endproperty
  a_invalid_real: assert property (p_invalid_real) else $error("real mode task load not invalid");

  property p_tr_clocks;
    @(posedge CLK_I) disable iff (RST_I)
      (state_reg == pic_pkg::PIC_CHECK && pmode && is_sys0 && regf == `PIC_REG_011 && !res_next.fault)
      |=> (count_reg == 8'd23 || count_reg == 8'd27);
  endproperty
  a_tr_clocks: assert property (p_tr_clocks) else $error("task load clock count wrong");

  property p_tbl_store;
    @(posedge CLK_I) disable iff (RST_I)
      (state_reg == pic_pkg::PIC_CHECK && is_sys1 && regf == `PIC_REG_000 && !res_next.fault)
      |=> count_reg == 8'd9;
  endproperty
  a_tbl_store: assert property (p_tbl_store) else $error("table store not 9 clocks");

  property p_fault_no_wb;
    @(posedge CLK_I) disable iff (RST_I)
      (state_reg == pic_pkg::PIC_DONE && res_reg.fault) |=> ($stable(flags_reg) && faults_reg[8]);
  endproperty
  a_fault_no_wb: assert property (p_fault_no_wb) else $error("faulting op changed flags");

  property p_pe_sticky;
    @(posedge CLK_I) disable iff (RST_I)
      $past(flags_reg[31]) |-> flags_reg[31];
  endproperty
  a_pe_sticky: assert property (p_pe_sticky) else $error("status load cleared protected flag");

  property p_lock_exec;
    @(posedge CLK_I) disable iff (RST_I)
      BUS_LOCK_O |-> (state_reg == pic_pkg::PIC_EXEC && res_reg.lock);
  endproperty
  a_lock_exec: assert property (p_lock_exec) else $error("lock outside locked execution");

  property p_priv_fault;
    @(posedge CLK_I) disable iff (RST_I)
      (state_reg == pic_pkg::PIC_CHECK && pmode && ctrl_reg[14] && current_privilege_level != 2'h0)
      |-> res_next.fault;
  endproperty
  a_priv_fault: assert property (p_priv_fault) else $error("privileged op at nonzero level ran");

  property p_mul_min;
    @(posedge CLK_I) disable iff (RST_I)
      (state_reg == pic_pkg::PIC_CHECK && ctrl_reg[25] && !is_sys0 && !is_sys1 && operand_reg == 32'h0 && !ctrl_reg[20] && !ctrl_reg[21])
      |-> res_next.clocks == 8'd12;
  endproperty
  a_mul_min: assert property (p_mul_min) else $error("zero multiplier count not 12");

  property p_local_store;
    @(posedge CLK_I) disable iff (RST_I)
      (state_reg == pic_pkg::PIC_CHECK && is_sys0 && regf == `PIC_REG_000 && !res_next.fault)
      |=> count_reg == 8'd2;
  endproperty
  a_local_store: assert property (p_local_store) else $error("local table store not 2 clocks");

  property p_lock_task_load;
    @(posedge CLK_I) disable iff (RST_I)
      (state_reg == pic_pkg::PIC_CHECK && is_sys0 && regf == `PIC_REG_011 && !res_next.fault)
      |=> BUS_LOCK_O;
  endproperty
  a_lock_task_load: assert property (p_lock_task_load) else $error("task load ran without bus lock");

  property p_verify_zero;
    @(posedge CLK_I) disable iff (RST_I)
      (state_reg == pic_pkg::PIC_CHECK && is_sys0 && regf == `PIC_REG_100 && ctrl_reg[7:6] > ctrl_reg[9:8])
      |-> !res_next.zero_flag;
  endproperty
  a_verify_zero: assert property (p_verify_zero) else $error("verify kept zero flag on violation");

endmodule

/* File: pic_params.svh */
// Constants of the protection instruction check unit: encodings, vectors, clock counts, APB map.
// Assumes an APB slave with 32-bit data and byte addresses; included by bare name.
// -------------------------------------------------------------------------
// How it works
// -------------------------------------------------------------------------
// How it works
// - Task register load: 0F, 00, reg 011.
// - Global table store: 0F 01 reg 000, 9 clocks.
// - Interrupt table store: 0F 01 reg 001, 9 clocks.
// - Local table store reg 000, protected, 2 clocks.
// - Protected-only opcode in real mode raises vector 6.
// - Real mode beyond FFFFH raises fault 13.
// - Real mode stack limit overrun raises fault 12.
// - Multiply clocks: max(ceil log2 |m|, 3) plus b.
// - b is 9, 12, 10 or 11 by form.
// - Designated instructions assert bus lock without prefix.
// - Descriptor table accesses run with bus lock asserted.
// - Protected operand limit or rights fault 13, stack 12.
// - Segment load privilege 13; not present 11, stack 12.
// - Far transfers breaking privilege raise fault 13.
// - Privileged instructions fault 13 above level zero.
// - I/O-sensitive fault 13 above I/O threshold.
// - Flag loads guard interrupt flag, threshold and 86 flag.
// - Status word load never clears protected mode flag.
// - Access verify violation clears zero flag, no fault; in real mode it faults 6.
// - Coprocessor operand faults 13, stack start 12, first.
// - Transfer target beyond code limit raises fault 13.
// - Global/interrupt table loads reg 010/011, 11 clocks.
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH
`define PIC_ESCAPE_BYTE    8'h0f
`define PIC_SECOND_SYS0    8'h00
`define PIC_SECOND_SYS1    8'h01
`define PIC_REG_000        3'h0
`define PIC_REG_001        3'h1
`define PIC_REG_010        3'h2
`define PIC_REG_011        3'h3
`define PIC_REG_100        3'h4
`define PIC_REG_101        3'h5
`define PIC_REG_110        3'h6
`define PIC_VEC_INVALID    8'h06
`define PIC_VEC_NOT_PRES   8'h0b
`define PIC_VEC_STACK      8'h0c
`define PIC_VEC_GENERAL    8'h0d
`define PIC_REAL_LIMIT     32'h0000ffff
`define PIC_CLK_TR_LOAD    8'h17
`define PIC_CLK_TR_LOAD_M  8'h1b
`define PIC_CLK_TBL_STORE  8'h09
`define PIC_CLK_LCL_STORE  8'h02
`define PIC_CLK_TBL_LOAD   8'h0b
`define PIC_CLK_RD_VFY     8'h0a
`define PIC_CLK_RD_VFY_M   8'h0b
`define PIC_CLK_WR_VFY     8'h0f
`define PIC_CLK_WR_VFY_M   8'h10
`define PIC_MUL_MIN        8'h03
`define PIC_B_RR           8'h09
`define PIC_B_MR           8'h0c
`define PIC_B_RI           8'h0a
`define PIC_B_MI           8'h0b
`define PIC_ADDR_CTRL      12'h000
`define PIC_ADDR_STATUS    12'h004
`define PIC_ADDR_RESULT    12'h008
`define PIC_ADDR_FAULTS    12'h00c
`define PIC_ADDR_SEGLIM    12'h010
`define PIC_ADDR_CODELIM   12'h014
`endif

/* File: pic_pkg.sv */
// Types of the protection instruction check unit.
// Assumes pic_params.svh for the numeric constants.
package pic_pkg;
  typedef enum logic [3:0] {
    PIC_IDLE  = 4'b0001,
    PIC_CHECK = 4'b0010,
    PIC_EXEC  = 4'b0100,
    PIC_DONE  = 4'b1000
  } pic_state_e;

  typedef struct packed {
    logic [7:0] escape_byte;
    logic [7:0] second_byte;
    logic [7:0] modrm_byte;
  } pic_instr_s;

  typedef struct packed {
    logic       fault;
    logic [7:0] vector;
    logic [7:0] clocks;
    logic       lock;
    logic       zero_flag;
    logic       write_back;
  } pic_result_s;
endpackage

/* File: tb_pic_check_unit.sv */
// Self-checking bench for the protection instruction check unit, driven over APB.
// Assumes pic_params.svh and the unit are compiled first; each check compares against expected values fixed in the bench.
`include "pic_params.svh"

module tb_pic_check_unit;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------------
  // Control bits and opcodes
  // ---------------------------------------------------------------------
  localparam logic [31:0] PM  = 32'h2, LCK = 32'h80000, MEM = 32'h100000, IMM = 32'h200000;
  localparam logic [31:0] STK = 32'h400000, BAD = 32'h800000, COP = 32'h1000000, MUL = 32'h2000000;
  localparam logic [31:0] XFR = 32'h4000000, SEG = 32'h1000, SSL = 32'h800, PRS = 32'h400;
  localparam logic [31:0] FAR = 32'h2000, PRV = 32'h4000, IOS = 32'h8000, FLG = 32'h10000;
  localparam logic [31:0] STL = 32'h20000, NPE = 32'h40000;
  localparam logic [23:0] I_TRL = 24'h0f00d8, I_GST = 24'h0f01c0, I_IST = 24'h0f01c8, I_LST = 24'h0f00c0;
  localparam logic [23:0] I_GLD = 24'h0f01d0, I_ILD = 24'h0f01d8, I_VFY = 24'h0f00e0, I_MUL = 24'h0fafc0;

  logic        clk, rst, psel, penable, pwrite, pready, pslverr, bus_lock, lock_hi;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, res, flt, q;
  int          bad_count = 0;
  int          checks = 0;
  int          lock_cnt = 0;

  pic_check_unit dut (
    .CLK_I      (clk),
    .RST_I      (rst),
    .PSEL_I     (psel),
    .PENABLE_I  (penable),
    .PWRITE_I   (pwrite),
    .PADDR_I    (paddr),
    .PWDATA_I   (pwdata),
    .PRDATA_O   (prdata),
    .PREADY_O   (pready),
    .PSLVERR_O  (pslverr),
    .BUS_LOCK_O (bus_lock)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (bus_lock === 1'b1) lock_cnt <= lock_cnt + 1;
  end

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic summarize();
    $display("Counts: checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The request stands until pready is seen high, so a slow answer is also handled.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      summarize();
    end else begin
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic run(input logic [23:0] ins, input logic [31:0] opnd, input logic [31:0] lim,
                     input logic [31:0] ctl);
    logic [31:0] st;
    int          n, l0;
    n = 0;
    apb(1'b1, `PIC_ADDR_STATUS, {8'h00, ins}, st);
    apb(1'b1, `PIC_ADDR_RESULT, opnd, st);
    apb(1'b1, `PIC_ADDR_SEGLIM, lim, st);
    apb(1'b1, `PIC_ADDR_CODELIM, 32'h00001000, st);
    l0 = lock_cnt;
    apb(1'b1, `PIC_ADDR_CTRL, ctl | 32'h1, st);
    do begin
      apb(1'b0, `PIC_ADDR_STATUS, 32'h0, st);
      n++;
    end while (st[27:24] !== 4'b0001 && n < 100);
    if (n >= 100) begin
      bad_count++;
      summarize();
    end else begin
      apb(1'b0, `PIC_ADDR_RESULT, 32'h0, res);
      apb(1'b0, `PIC_ADDR_FAULTS, 32'h0, flt);
      lock_hi = (lock_cnt != l0);
    end
  endtask

  // Kind 1 expects fault vector v, kind 0 no fault and v clocks, kind 2 only no fault.
  task automatic chk(input logic [23:0] ins, input logic [31:0] opnd, input logic [31:0] lim,
                     input logic [31:0] ctl, input int kind, input logic [7:0] v);
    run(ins, opnd, lim, ctl);
    if (kind == 1) begin
      cmp({23'h0, flt[8:0]}, {23'h0, 1'b1, v});
      cmp({31'h0, res[17]}, 32'h0);
    end else begin
      cmp({31'h0, flt[8]}, 32'h0);
      if (kind == 0) cmp({24'h0, res[15:8]}, {24'h0, v});
    end
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_bus();
    cmp(prdata, 32'h0);
    cmp({30'h0, bus_lock, pslverr}, 32'h0);
    apb(1'b0, 12'h020, 32'h0, q);
    cmp(q, 32'h0);
    apb(1'b1, `PIC_ADDR_FAULTS, 32'h000001ff, q);
    apb(1'b0, `PIC_ADDR_FAULTS, 32'h0, q);
    cmp(q, 32'h0);
    $display("test bus done");
  endtask

  task automatic t_decode();
    chk(I_TRL, 0, 0, PM, 0, 8'd23);
    chk(24'h0f0018, 0, 0, PM | MEM, 0, 8'd27);
    chk(I_TRL, 0, 0, 0, 1, 8'd6);
    chk(I_GST, 0, 0, 0, 0, 8'd9);
    chk(I_GST, 0, 0, PM, 0, 8'd9);
    chk(I_IST, 0, 0, 0, 0, 8'd9);
    chk(I_IST, 0, 0, PM, 0, 8'd9);
    chk(I_LST, 0, 0, PM, 0, 8'd2);
    chk(I_LST, 0, 0, 0, 1, 8'd6);
    chk(24'h0f0000, 0, 0, PM | MEM, 0, 8'd2);
    chk(I_VFY, 0, 0, 0, 1, 8'd6);
    chk(I_GLD, 0, 0, 0, 0, 8'd11);
    chk(I_ILD, 0, 0, 0, 0, 8'd11);
    $display("test decode done");
  endtask

  task automatic t_faults();
    chk(I_GST, 0, 32'h10000, MEM, 1, 8'd13);
    chk(I_GST, 0, 32'hffff, MEM, 0, 8'd9);
    chk(I_GST, 0, 32'h10000, MEM | STK, 1, 8'd12);
    chk(I_GST, 0, 0, PM | MEM | BAD, 1, 8'd13);
    chk(I_GST, 0, 0, PM | MEM | STK | BAD, 1, 8'd12);
    chk(I_GST, 0, 0, PM | SEG | PRS | 32'hc, 1, 8'd13);
    chk(I_GST, 0, 0, PM | SEG, 1, 8'd11);
    chk(I_GST, 0, 0, PM | SEG | SSL, 1, 8'd12);
    chk(I_GST, 0, 0, PM | SEG | PRS | 32'h300, 2, 8'd0);
    chk(I_GST, 0, 0, PM | FAR, 1, 8'd13);
    chk(I_GST, 0, 0, PM | PRV | 32'h4, 1, 8'd13);
    chk(I_GST, 0, 0, PM | PRV, 2, 8'd0);
    chk(I_GST, 0, 0, PM | IOS | 32'h18, 1, 8'd13);
    chk(I_GST, 0, 0, PM | IOS | 32'h14, 2, 8'd0);
    chk(I_GST, 0, 0, PM | COP | MEM | BAD, 1, 8'd13);
    chk(I_GST, 0, 0, PM | COP | MEM | STK | BAD, 1, 8'd12);
    chk(I_GST, 32'h1001, 0, PM | XFR, 1, 8'd13);
    chk(I_GST, 32'h1000, 0, PM | XFR, 2, 8'd0);
    chk(I_TRL, 0, 32'h10000, MEM, 1, 8'd6);
    $display("test faults done");
  endtask

  task automatic t_mul();
    logic [31:0] mv [4];
    logic [7:0]  lg [4];
    logic [7:0]  bv [4];
    mv = '{32'd0, 32'd2, 32'd256, 32'd1000};
    lg = '{8'd3, 8'd3, 8'd8, 8'd10};
    bv = '{8'd9, 8'd12, 8'd10, 8'd11};
    for (int f = 0; f < 4; f++) begin
      for (int i = 0; i < 4; i++) begin
        run(I_MUL, mv[i], 0, MUL | (f[0] ? MEM : 32'h0) | (f[1] ? IMM : 32'h0));
        cmp({24'h0, res[15:8]}, {24'h0, lg[i] + bv[f]});
      end
    end
    $display("test multiply done");
  endtask

  task automatic t_lock();
    run(I_GST, 0, 0, PM | LCK);
    cmp({31'h0, res[16]}, 32'h1);
    cmp({31'h0, lock_hi}, 32'h1);
    run(I_GST, 0, 0, PM);
    cmp({31'h0, lock_hi}, 32'h0);
    run(I_VFY, 0, 0, PM | PRS | 32'hcc);
    cmp({23'h0, flt[8], 7'h0, res[18]}, 32'h0);
    run(I_VFY, 0, 0, PM | PRS | 32'h300);
    cmp({23'h0, flt[8], 7'h0, res[18]}, 32'h1);
    cmp({31'h0, lock_hi}, 32'h1);
    run(I_TRL, 0, 0, PM);
    cmp({31'h0, res[16]}, 32'h1);
    cmp({31'h0, lock_hi}, 32'h1);
    $display("test lock done");
  endtask

  task automatic t_flags();
    run(I_GST, 32'h23200, 0, PM | FLG);
    apb(1'b0, `PIC_ADDR_SEGLIM, 32'h0, q);
    cmp(q & 32'h23200, 32'h23200);
    run(I_GST, 32'h0, 0, PM | FLG | 32'h18);
    apb(1'b0, `PIC_ADDR_SEGLIM, 32'h0, q);
    cmp(q & 32'h23200, 32'h23200);
    run(I_GST, 32'h0, 0, PM | FLG | 32'h14);
    apb(1'b0, `PIC_ADDR_SEGLIM, 32'h0, q);
    cmp(q & 32'h23200, 32'h23000);
    run(I_GST, 0, 0, PM | STL | NPE);
    run(I_GST, 0, 0, PM | STL);
    apb(1'b0, `PIC_ADDR_SEGLIM, 32'h0, q);
    cmp({31'h0, q[31]}, 32'h1);
    $display("test flags done");
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_bus();
    t_decode();
    t_faults();
    t_mul();
    t_lock();
    t_flags();
    summarize();
  end
endmodule
